// ===== verilog/lbst_top.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "lbst_params.svh"
module lbst_top (
	input wire logic clk_i, // core clock 250 MHz
	input wire logic resetn_i, // async reset, low
	input wire logic clk_en_i, // freeze when low
	input wire logic link_clk_i, // recovered link pixel clock
	input wire logic [15:0] rx_payload_i, // received payload
	input wire logic [3:0] rx_crc_i, // received check code
	input wire logic lock_i, // receiver lock pin
	input wire logic self_test_window_i, // test window pin
	input wire logic chip_enable_n_i, // low = powerdown
	input wire logic camera_mode_i, // config pin, high = camera
	input wire logic [1:0] clk_sel_i, // test clock select pins
	input wire logic bc_err_i, // back channel error flag
	input wire logic [7:0] addr_i, // register address
	input wire logic [31:0] wdata_i, // write data
	input wire logic we_i, // write strobe
	input wire logic re_i, // read strobe
	output logic [31:0] rdata_o, // read data, cycle after re_i
	output logic pass_o, // link-ok pin
	output logic ser_test_cmd_o, // back channel test command
	output logic [1:0] ser_clk_sel_o, // test clock code to serializer
	output logic irq_o // level interrupt
);
	localparam logic [3:0] HALF_CYC = 4'(`LBST_HALF_CYC);

	lbst_pkg::lbst_pins_t pins_raw;
	lbst_pkg::lbst_pins_t pins;
	lbst_pkg::lbst_sym_t sym_raw;
	lbst_pkg::lbst_sym_t sym;
	lbst_pkg::lbst_state_t st_r;
	lbst_pkg::lbst_state_t st_nxt;

	logic link_clk_d_r;
	logic bc_err_d_r;
	logic pwr_en_d_r;
	logic [15:0] cap_payload_r;
	logic [3:0] cap_crc_r;
	logic cap_v_r;
	logic [15:0] prev_r;
	logic seed_v_r;
	logic [3:0] crc_calc;
	logic [15:0] expect_word;
	logic [4:0] bad_bits;
	logic frame_bad;
	logic [4:0] fail_cnt;
	logic err_seen_r;
	logic result_r;
	logic [7:0] pend_r;
	logic [3:0] ph_cnt_r;
	logic low_r;
	logic [15:0] err_cnt_r;
	logic [15:0] bc_cnt_r;
	logic ctrl_en_r;
	logic [3:0] istat_r;
	logic [3:0] imask_r;
	logic [3:0] ev;
	logic [1:0] sel_lat_r;
	logic cmd_want;
	logic start_ev;
	logic end_ev;
	logic bc_rise;
	logic link_rise;
	logic pwr_release;
	logic wr_istat;
	logic wr_imask;
	logic wr_ctrl;

	assign pins_raw.link_clk = link_clk_i;
	assign pins_raw.window = self_test_window_i;
	assign pins_raw.lock = lock_i;
	assign pins_raw.pwr_en = chip_enable_n_i;
	assign pins_raw.camera = camera_mode_i;
	assign pins_raw.clk_sel = clk_sel_i;
	assign pins_raw.bc_err = bc_err_i;
	assign sym_raw.payload = rx_payload_i;
	assign sym_raw.crc = rx_crc_i;

	lbst_sync3 #(
		.W($bits(lbst_pkg::lbst_pins_t))
	) u_pin_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.d_i(pins_raw),
		.q_o(pins)
	);

	// data take the same latency so they line up with the clock edge
	lbst_sync3 #(
		.W($bits(lbst_pkg::lbst_sym_t))
	) u_sym_sync (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.d_i(sym_raw),
		.q_o(sym)
	);

	lbst_crc4 u_crc (
		.data_i(cap_payload_r),
		.crc_o(crc_calc)
	);

	function automatic logic [15:0] prbs_next(input logic [15:0] s);
		logic [15:0] r;
		logic fb;
		r = s;
		for (int i = 0; i < 16; i++)
		begin
			fb = r[15] ^ r[13] ^ r[12] ^ r[10];
			r = {r[14:0], fb};
		end
		return r;
	endfunction : prbs_next

	function automatic logic [4:0] popcnt(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++)
		begin
			n = n + {4'h0, v[i]};
		end
		return n;
	endfunction : popcnt

	assign link_rise = pins.link_clk & ~link_clk_d_r;
	assign bc_rise = pins.bc_err & ~bc_err_d_r;
	assign pwr_release = pins.pwr_en & ~pwr_en_d_r;
	// powered, camera config, software enable, window high
	assign cmd_want = pins.window & pins.camera & pins.pwr_en & ctrl_en_r; // [RL4] [RL7]
	assign start_ev = (st_r == lbst_pkg::ST_WAIT_LOCK) && cmd_want && pins.lock;
	assign end_ev = (st_r == lbst_pkg::ST_RUN) && !(cmd_want && pins.lock);

	assign expect_word = prbs_next(prev_r); // [RL9]
	assign bad_bits = seed_v_r ? popcnt(expect_word ^ cap_payload_r) : 5'h00;
	// check code mismatch alone still counts as one failing bit
	assign frame_bad = (crc_calc != cap_crc_r) || (bad_bits != 5'h00); // [RL17]
	assign fail_cnt = (bad_bits != 5'h00) ? bad_bits : {4'h0, frame_bad};

	assign wr_ctrl = we_i && (addr_i == `LBST_OFS_CTRL);
	assign wr_istat = we_i && (addr_i == `LBST_OFS_ISTAT);
	assign wr_imask = we_i && (addr_i == `LBST_OFS_IMASK);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			link_clk_d_r <= 1'b0;
			bc_err_d_r <= 1'b0;
			pwr_en_d_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			link_clk_d_r <= pins.link_clk;
			bc_err_d_r <= pins.bc_err;
			pwr_en_d_r <= pins.pwr_en;
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			lbst_pkg::ST_IDLE:
			begin
				if (cmd_want)
					st_nxt = lbst_pkg::ST_WAIT_LOCK;
			end
			lbst_pkg::ST_WAIT_LOCK:
			begin
				if (!cmd_want)
					st_nxt = lbst_pkg::ST_IDLE;
				else if (pins.lock)
					st_nxt = lbst_pkg::ST_RUN; // [RL1]
			end
			lbst_pkg::ST_RUN:
			begin
				if (!(cmd_want && pins.lock))
					st_nxt = lbst_pkg::ST_IDLE; // [RL1] [RL2]
			end
			default:
				st_nxt = lbst_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st_r <= lbst_pkg::ST_IDLE;
		else if (clk_en_i)
			st_r <= st_nxt;
	end

	// back channel command holds while test mode is wanted
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ser_test_cmd_o <= 1'b0;
			ser_clk_sel_o <= 2'b00;
			sel_lat_r <= 2'b00;
		end
		else if (clk_en_i)
		begin
			ser_test_cmd_o <= cmd_want; // [RL7]
			if ((st_r == lbst_pkg::ST_IDLE) && cmd_want)
			begin
				// code frozen for the session so the rate never moves mid-test
				sel_lat_r <= pins.clk_sel; // [RL5] [RL6]
				ser_clk_sel_o <= pins.clk_sel; // [RL5]
			end
		end
	end

	// capture one symbol per link clock rising edge
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cap_payload_r <= 16'h0000;
			cap_crc_r <= 4'h0;
			cap_v_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			cap_v_r <= link_rise && (st_r == lbst_pkg::ST_RUN) && pins.lock; // [RL15]
			if (link_rise)
			begin
				cap_payload_r <= sym.payload;
				cap_crc_r <= sym.crc;
			end
		end
	end

	// self-synchronising reference: next word predicted from the last one
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			prev_r <= 16'h0000;
			seed_v_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (start_ev)
				seed_v_r <= 1'b0;
			else if (cap_v_r)
			begin
				prev_r <= cap_payload_r;
				seed_v_r <= 1'b1;
			end
		end
	end

	// result flag: held outside sessions, defaults high after powerdown
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			err_seen_r <= 1'b0;
			result_r <= 1'b1;
		end
		else if (clk_en_i)
		begin
			if (pwr_release)
			begin
				err_seen_r <= 1'b0;
				result_r <= 1'b1; // [RL13]
			end
			else if (start_ev)
				err_seen_r <= 1'b0;
			else if (cap_v_r && frame_bad && (st_r == lbst_pkg::ST_RUN))
				err_seen_r <= 1'b1; // [RL2]
			if (end_ev)
				result_r <= !err_seen_r; // [RL3]
		end
	end

	// fail pulse train, half a link clock low then half high per bit
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pend_r <= 8'h00;
			ph_cnt_r <= 4'h0;
			low_r <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (st_r != lbst_pkg::ST_RUN)
			begin
				pend_r <= 8'h00; // [RL2]
				ph_cnt_r <= 4'h0;
				low_r <= 1'b0;
			end
			else
			begin
				logic [8:0] sum;
				logic [7:0] p;
				sum = {1'b0, pend_r} + {4'h0, (cap_v_r ? fail_cnt : 5'h00)};
				p = sum[8] ? 8'hFF : sum[7:0];
				if (ph_cnt_r != 4'h0)
					ph_cnt_r <= ph_cnt_r - 4'h1;
				else if (low_r)
				begin
					low_r <= 1'b0;
					ph_cnt_r <= HALF_CYC - 4'h1;
					p = p - 8'h01;
				end
				else if (p != 8'h00)
				begin
					low_r <= 1'b1; // [RL10]
					ph_cnt_r <= HALF_CYC - 4'h1;
				end
				pend_r <= p;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pass_o <= 1'b1;
		else if (clk_en_i)
		begin
			if (st_r == lbst_pkg::ST_RUN)
				pass_o <= !low_r; // [RL10]
			else
				pass_o <= result_r; // [RL3] [RL13]
		end
	end

	// counters saturate instead of wrapping so a long soak never reads low
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			err_cnt_r <= 16'h0000;
			bc_cnt_r <= 16'h0000;
		end
		else if (clk_en_i)
		begin
			if (start_ev)
			begin
				err_cnt_r <= 16'h0000; // [RL19]
				bc_cnt_r <= 16'h0000; // [RL19]
			end
			else if (st_r == lbst_pkg::ST_RUN)
			begin
				logic [16:0] s;
				s = {1'b0, err_cnt_r} + {12'h000, (cap_v_r ? fail_cnt : 5'h00)};
				err_cnt_r <= s[16] ? 16'hFFFF : s[15:0]; // [RL11]
				if (bc_rise && (bc_cnt_r != 16'hFFFF))
					bc_cnt_r <= bc_cnt_r + 16'h0001; // [RL12]
			end
		end
	end

	assign ev[`LBST_IRQ_START] = start_ev;
	assign ev[`LBST_IRQ_END] = end_ev;
	assign ev[`LBST_IRQ_FRAME] = cap_v_r && frame_bad;
	assign ev[`LBST_IRQ_BC] = bc_rise && (st_r == lbst_pkg::ST_RUN);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_en_r <= `LBST_CTRL_RST;
			imask_r <= `LBST_IMASK_RST;
			istat_r <= 4'h0;
			irq_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (wr_ctrl)
				ctrl_en_r <= wdata_i[0];
			if (wr_imask)
				imask_r <= wdata_i[3:0];
			// a new event beats a clear in the same cycle
			istat_r <= (istat_r & ~(wr_istat ? wdata_i[3:0] : 4'h0)) | ev;
			irq_o <= |(istat_r & imask_r);
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= 32'h0000_0000;
		else if (clk_en_i)
		begin
			rdata_o <= 32'h0000_0000;
			if (re_i)
			begin
				case (addr_i)
					`LBST_OFS_CTRL:
						rdata_o <= {31'h0000_0000, ctrl_en_r};
					`LBST_OFS_STAT:
						rdata_o <= {26'h000_0000, sel_lat_r, pins.lock,
							pass_o, (st_r == lbst_pkg::ST_RUN),
							ser_test_cmd_o}; // [RL16]
					`LBST_OFS_ERRCNT:
						rdata_o <= {16'h0000, err_cnt_r}; // [RL11]
					`LBST_OFS_BCERR:
						rdata_o <= {16'h0000, bc_cnt_r};
					`LBST_OFS_ISTAT:
						rdata_o <= {28'h000_0000, istat_r};
					`LBST_OFS_IMASK:
						rdata_o <= {28'h000_0000, imask_r};
					default:
						rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : lbst_top
`default_nettype wire

// ===== verilog/lbst_params.svh
// Notes on behaviour
// RL1: session starts once receiver lock and test window are both high; lasts while both hold
// RL2: window fall ends the session; later payload errors never reach the result
// RL3: at session end link-ok is high if all payloads clean, low otherwise
// RL4: self test runs only in camera configuration, never in display configuration
// RL5: two select pins pick test clock: external, 50, 25 or 12.5 MHz
// RL6: code 00 bypasses oscillator; system must feed serializer pixel clock input
// RL7: entering test mode commands the serializer into test mode over back channel
// RL8: controller waits 10 ms, then watches lock rise before trusting status; the code has no wait and enters ST_RUN as soon as lock is high
// RL9: serializer sends internal pseudo-random sequence instead of parallel data
// RL10: each failing bit drops link-ok low half a link clock, then high half
// RL11: an error count accumulates during the test and is readable
// RL12: serializer pin 0 flags back channel errors during self test
// RL13: result held until new session or powerdown toggle; then defaults high
// RL14: after the window the system drives normal parallel data again
// RL15: only payload errors count; recovery failures show on lock only
// RL16: link-ok is valid only while receiver lock is high
// RL17: each symbol carries a 4-bit check code used to detect payload errors
// RL18: camera mode needs serializer config pin low, deserializer config pin high
// RL19: error counters clear at the start of every new session
`ifndef LBST_PARAMS_SVH
`define LBST_PARAMS_SVH

`define LBST_ADDR_W 8
`define LBST_OFS_CTRL 8'h00
`define LBST_OFS_STAT 8'h04
`define LBST_OFS_ERRCNT 8'h08
`define LBST_OFS_BCERR 8'h0C
`define LBST_OFS_ISTAT 8'h10
`define LBST_OFS_IMASK 8'h14

`define LBST_CTRL_RST 1'h1
`define LBST_IMASK_RST 4'h0

`define LBST_IRQ_START 0
`define LBST_IRQ_END 1
`define LBST_IRQ_FRAME 2
`define LBST_IRQ_BC 3

`define LBST_STAT_CMD 0
`define LBST_STAT_RUN 1
`define LBST_STAT_PASS 2
`define LBST_STAT_VALID 3
`define LBST_STAT_SEL 4

`define LBST_CLK_PERIOD_NS 4
`define LBST_LINK_PERIOD_NS 64
`define LBST_HALF_CYC ((`LBST_LINK_PERIOD_NS / 2) / `LBST_CLK_PERIOD_NS)
`define LBST_LOCK_WAIT_MS 10

`endif

// ===== verilog/lbst_pkg.sv
package lbst_pkg;

	typedef struct packed {
		logic link_clk;
		logic window;
		logic lock;
		logic pwr_en;
		logic camera;
		logic [1:0] clk_sel;
		logic bc_err;
	} lbst_pins_t;

	typedef struct packed {
		logic [15:0] payload;
		logic [3:0] crc;
	} lbst_sym_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_LOCK,
		ST_RUN
	} lbst_state_t;

endpackage : lbst_pkg

// ===== verilog/lbst_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module lbst_sync3 #(
	parameter int W = 1
) (
	input wire logic clk_i, // core clock
	input wire logic resetn_i, // async reset, low
	input wire logic clk_en_i, // freeze when low
	input wire logic [W-1:0] d_i, // asynchronous inputs
	output logic [W-1:0] q_o // filtered, synchronous
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_o <= '0;
		end
		else if (clk_en_i)
		begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// a bit moves only once stages two and three agree
			q_o <= (s2_r & s3_r) | (q_o & (s2_r | s3_r));
		end
	end
endmodule : lbst_sync3
`default_nettype wire

// ===== verilog/lbst_crc4.sv
`timescale 1ns/10ps
`default_nettype none
module lbst_crc4 (
	input wire logic [15:0] data_i, // payload word
	output logic [3:0] crc_o // check code, x^4+x+1
);
	always_comb
	begin
		logic [3:0] c;
		logic fb;
		c = 4'h0;
		fb = 1'b0;
		for (int i = 15; i >= 0; i--)
		begin
			fb = c[3] ^ data_i[i];
			c = {c[2:0], 1'b0} ^ {2'b00, fb, fb};
		end
		crc_o = c;
	end
endmodule : lbst_crc4
`default_nettype wire

// ===== sim/lbst_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module lbst_monitor (
	input wire logic clk_i, // core clock
	input wire logic resetn_i, // reset, low
	input wire logic clk_en_i, // freeze when low
	input wire logic self_test_window_i, // window pin
	input wire logic chip_enable_n_i, // low = powerdown
	input wire logic camera_mode_i, // camera config
	input wire logic re_i, // read strobe
	input wire logic [31:0] rdata_o, // read data
	input wire logic pass_o, // link-ok
	input wire logic ser_test_cmd_o, // test command
	input wire logic [1:0] ser_clk_sel_o // clock code
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_reset_pass_high: assert property ($rose(resetn_i) |-> pass_o)
		else $error("link-ok low after reset");
	a_no_display_test: assert property (!camera_mode_i [*8] |-> !ser_test_cmd_o)
		else $error("test command in display configuration");
	a_window_gates_cmd: assert property (!self_test_window_i [*8] |-> !ser_test_cmd_o)
		else $error("test command without window");
	// filter plus register take about five cycles, eight leaves margin
	// a frozen block cannot answer, so entry counts only while enabled
	a_cmd_on_entry: assert property ((self_test_window_i && camera_mode_i
		&& chip_enable_n_i && clk_en_i) [*8] |-> ser_test_cmd_o)
		else $error("no test command after entry");
	a_sel_held: assert property (ser_test_cmd_o && $past(ser_test_cmd_o)
		|-> $stable(ser_clk_sel_o))
		else $error("clock code moved in session");
	a_result_held: assert property ((!ser_test_cmd_o && chip_enable_n_i) [*8]
		|=> $stable(pass_o))
		else $error("result changed outside session");
	a_fail_low_half: assert property ($fell(pass_o) |-> !pass_o [*8])
		else $error("fail pulse shorter than half link clock");
	a_fail_high_half: assert property ($rose(pass_o) && ser_test_cmd_o
		&& $past(ser_test_cmd_o) |-> pass_o [*8])
		else $error("pulse gap shorter than half link clock");
	a_rdata_idle_zero: assert property (!$past(re_i) |-> rdata_o == 32'h0)
		else $error("read data outside read cycle");
endmodule : lbst_monitor

bind lbst_top lbst_monitor lbst_monitor_i (.clk_i, .resetn_i, .clk_en_i,
	.self_test_window_i, .chip_enable_n_i, .camera_mode_i, .re_i,
	.rdata_o, .pass_o, .ser_test_cmd_o, .ser_clk_sel_o);
`default_nettype wire

// ===== sim/lbst_ser_model.sv
`timescale 1ns/10ps
`default_nettype none
module lbst_ser_model (
	input wire logic run_i, // test traffic ordered
	input wire logic bad_crc_i, // spoil check code
	output logic link_clk_o, // still between runs
	output logic [15:0] payload_o, // symbol word
	output logic [3:0] crc_o // symbol check code
);
	logic [15:0] r;
	logic [3:0] c;
	int i;
	initial
	begin
		r = 16'hACE1;
		link_clk_o = 1'b0;
		payload_o = ~r;
		crc_o = 4'hF;
	end
	always
	begin
		// out of test mode the word stands still, like idle parallel data
		wait (run_i);
		// one ns off the core grid so the new word does not race the bench
		#1;
		c = 4'h0;
		for (i = 15; i >= 0; i--)
			c = {c[2:0], 1'b0} ^ ({4{c[3] ^ r[i]}} & 4'h3);
		payload_o = r;
		crc_o = c ^ {3'h0, bad_crc_i};
		// own clock stands in for the external pixel clock at code 00
		#15 link_clk_o = 1'b1;
		#32 link_clk_o = 1'b0;
		#16;
		for (i = 0; i < 16; i++)
			r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
		// hold time over: show no stale word
		payload_o = ~payload_o;
		crc_o = ~crc_o;
	end
endmodule : lbst_ser_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lbst_params.svh"
module tb;
	logic clk, resetn, link_clk, lock, win, pen, cam, bc, we, re;
	logic keep, bad, pass, cmd, irq, cen;
	logic [1:0] sel, csel;
	logic [15:0] payload;
	logic [3:0] crc;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	int miscompares, samples_checked, falls, k;

	always #2 clk = ~clk;
	always @(negedge pass) if (win) falls++;

	lbst_top lbst_top_i (.clk_i(clk), .resetn_i(resetn), .clk_en_i(cen),
		.link_clk_i(link_clk), .rx_payload_i(payload), .rx_crc_i(crc),
		.lock_i(lock), .self_test_window_i(win), .chip_enable_n_i(pen),
		.camera_mode_i(cam), .clk_sel_i(sel), .bc_err_i(bc), .addr_i(addr),
		.wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
		.pass_o(pass), .ser_test_cmd_o(cmd), .ser_clk_sel_o(csel),
		.irq_o(irq));
	lbst_ser_model lbst_ser_model_i (.run_i(cmd | keep), .bad_crc_i(bad),
		.link_clk_o(link_clk), .payload_o(payload), .crc_o(crc));

	task automatic conclude;
		$display("checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string m);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		// data launched at the last edge stand until this one
		@(posedge clk);
		chk(rdata, e, m);
	endtask : rd

	task automatic wait_cmd(input logic v);
		int i;
		for (i = 0; i < 100 && cmd !== v; i++)
			@(posedge clk);
		if (cmd !== v)
		begin
			chk(cmd, v, "command timeout");
			conclude;
		end
	endtask : wait_cmd

	// lock comes late so the first symbols of a session seed the sequence
	task automatic sess(input logic [1:0] s, input int n);
		int j;
		falls = 0;
		lock <= 1'b0;
		sel <= s;
		win <= 1'b1;
		wait_cmd(1'b1);
		chk(csel, s, "clock code");
		cyc(40);
		lock <= 1'b1;
		cyc(100);
		bc <= 1'b1;
		cyc(10);
		bc <= 1'b0;
		for (j = 0; j < n; j++)
		begin
			bad <= 1'b1;
			cyc(16);
			bad <= 1'b0;
			cyc(60);
		end
		cyc(40);
		win <= 1'b0;
		wait_cmd(1'b0);
		cyc(10);
		rd(`LBST_OFS_ERRCNT, n, "error count");
		chk(falls, n, "fail pulses");
		chk(pass, n == 0, "session result");
	endtask : sess

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		{lock, win, bc, we, re, keep, bad} = 7'h0;
		{pen, cam, cen} = 3'h7;
		sel = 2'h0;
		addr = 8'h0;
		wdata = 32'h0;
		miscompares = 0;
		samples_checked = 0;
		falls = 0;
		cyc(6);
		resetn <= 1'b1;
		cyc(2);
		chk({pass, irq, cmd}, 3'h4, "reset outputs");
		rd(`LBST_OFS_CTRL, 32'h1, "ctrl reset");
		rd(`LBST_OFS_IMASK, 32'h0, "mask reset");
		rd(8'h20, 32'h0, "unmapped read");
		$display("test reset done");
		cam <= 1'b0;
		win <= 1'b1;
		lock <= 1'b1;
		cyc(50);
		chk(cmd, 1'b0, "display mode test");
		{win, lock} <= 2'h0;
		cam <= 1'b1;
		cyc(10);
		$display("test display mode done");
		// a frozen block must not see the window until enabled again
		cen <= 1'b0;
		win <= 1'b1;
		cyc(20);
		chk(cmd, 1'b0, "command while frozen");
		cen <= 1'b1;
		wait_cmd(1'b1);
		win <= 1'b0;
		wait_cmd(1'b0);
		$display("test clock enable done");
		for (k = 0; k < 4; k++)
		begin
			sel <= k[1:0];
			win <= 1'b1;
			wait_cmd(1'b1);
			chk(csel, k[1:0], "clock code loop");
			win <= 1'b0;
			wait_cmd(1'b0);
		end
		wr(`LBST_OFS_ISTAT, 32'hF);
		$display("test clock codes done");
		wr(`LBST_OFS_IMASK, 32'hF);
		sess(2'h1, 0);
		rd(`LBST_OFS_BCERR, 32'h1, "back channel count");
		rd(`LBST_OFS_STAT, 32'h1C, "status after session");
		rd(`LBST_OFS_ISTAT, 32'hB, "status after clean run");
		chk(irq, 1'b1, "irq raised");
		keep <= 1'b1;
		bad <= 1'b1;
		cyc(48);
		{keep, bad} <= 2'h0;
		cyc(20);
		chk(pass, 1'b1, "late error seen");
		rd(`LBST_OFS_ERRCNT, 32'h0, "late error counted");
		wr(`LBST_OFS_ISTAT, 32'hF);
		cyc(3);
		chk(irq, 1'b0, "irq cleared");
		$display("test clean session done");
		wr(`LBST_OFS_IMASK, 32'h4);
		sess(2'h3, 3);
		rd(`LBST_OFS_ISTAT, 32'hF, "status after failed run");
		chk(irq, 1'b1, "frame irq");
		wr(`LBST_OFS_IMASK, 32'h0);
		cyc(3);
		chk(irq, 1'b0, "irq masked");
		wr(`LBST_OFS_ISTAT, 32'hF);
		$display("test failed session done");
		sess(2'h2, 0);
		sess(2'h0, 1);
		pen <= 1'b0;
		cyc(20);
		pen <= 1'b1;
		cyc(20);
		chk(pass, 1'b1, "powerdown toggle");
		$display("test powerdown done");
		conclude;
	end
endmodule : tb
`default_nettype wire
